/* File: dv/baseband_iq_sample_interface_tb_top.sv */
// bench: both link ends joined, one pair each way per config row
// assumes the hw package, header and interface compile first
`include "iq_link_regs.svh"
`default_nettype none
module baseband_iq_sample_interface_tb_top import iq_link_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_i, rst_i, tx_valid_i, tx_ready_o, rx_valid_o, cfg_write_i;
  logic       dac_clock_o, dac_valid_o, dac_ready_i, adc_clock_o;
  logic [3:0] bb;
  logic [7:0] cfg_wdata_i, cfg_rdata_o;
  iq_pair_t   tx_pair_i, rx_pair_o, dac_pair_o, adc_pair_i, adc_val, tv, dq[$], rq[$];
  int         bad_count, cmp_count, r, n;
  // row: baseband levels {rx_q, rx_pol, tx_q, tx_pol}, then config byte
  logic [11:0] rows [6] = '{12'h000, 12'h101, 12'h206, 12'h408, 12'h830, 12'hF3F};
  iq_link_if link ();
  iq_baseband_end u_iq_baseband_end (.clock_i(clock_i), .rst_i(rst_i),
    .tx_sync_pol_i(bb[0]), .tx_q_first_i(bb[1]), .rx_sync_pol_i(bb[2]), .rx_q_first_i(bb[3]),
    .tx_valid_i(tx_valid_i), .tx_pair_i(tx_pair_i), .tx_ready_o(tx_ready_o),
    .rx_valid_o(rx_valid_o), .rx_pair_o(rx_pair_o), .link(link.baseband));
  iq_converter_end u_iq_converter_end (.reset_n_i(!rst_i), .cfg_clock_i(clock_i),
    .cfg_write_i(cfg_write_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .dac_clock_o(dac_clock_o), .dac_valid_o(dac_valid_o), .dac_pair_o(dac_pair_o),
    .dac_ready_i(dac_ready_i), .adc_valid_i(1'b1), .adc_pair_i(adc_pair_i), .adc_ready_o(),
    .adc_clock_o(adc_clock_o), .link(link.converter));
  iq_link_properties u_iq_link_properties (.clock_i(clock_i), .rst_i(rst_i),
    .tx_clk(link.tx_clk), .transmit_frame_sync(link.transmit_frame_sync),
    .rx_clk(link.rx_clk), .receive_frame_sync(link.receive_frame_sync),
    .dac_clock_o(dac_clock_o), .adc_clock_o(adc_clock_o), .dac_valid_o(dac_valid_o),
    .dac_ready_i(dac_ready_i), .tx_ready_o(tx_ready_o), .rx_valid_o(rx_valid_o));
  //////////////////////////////////////////////////////////////////////
  // idle link sends zero pairs, so only nonzero pairs are collected
  always @(posedge link.tx_clk)
    if (dac_valid_o === 1'b1 && dac_ready_i === 1'b1 && dac_pair_o !== '0)
      dq.push_back(dac_pair_o);
  always @(posedge clock_i)
    if (rx_valid_o === 1'b1 && rx_pair_o !== '0)
      rq.push_back(rx_pair_o);
  always @(posedge link.rx_clk)
    adc_pair_i <= adc_val;
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic send(input iq_pair_t p);
    tx_valid_i <= 1'b1;
    tx_pair_i <= p;
    n = 0;
    do
    begin
      @(posedge clock_i);
      n++;
    end while (tx_ready_o !== 1'b1 && n < 20);
    tx_valid_i <= 1'b0;
  endtask
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  initial
  begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial
  begin
    {rst_i, tx_valid_i, cfg_write_i, dac_ready_i} = 4'h9;
    {bb, cfg_wdata_i} = 12'h000;
    {tx_pair_i, adc_val, adc_pair_i} = '0;
    // each row restarts from reset, so a second reset mid-run is covered
    for (r = 0; r < 6; r++)
    begin
      rst_i <= 1'b1;
      bb <= rows[r][11:8];
      adc_val <= '0;
      repeat (3) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      check(cfg_rdata_o, `CFG_RESET_VALUE);
      cfg_wdata_i <= rows[r][7:0];
      cfg_write_i <= 1'b1;
      @(posedge clock_i);
      cfg_write_i <= 1'b0;
      @(posedge clock_i);
      check(cfg_rdata_o, rows[r][7:0]);
      repeat (8) @(posedge clock_i);
      dq.delete();
      rq.delete();
      tv = {12'h800 + 12'(r), 12'h7F0 + 12'(r)};
      adc_val <= {12'hF00 + 12'(r), 12'h0A0 + 12'(r)};
      send(tv);
      repeat (60) @(posedge clock_i);
      check(dq.size() ? dq[0] : 24'h0, tv);
      check(rq.size() ? rq[0] : 24'h0, {12'hF00 + 12'(r), 12'h0A0 + 12'(r)});
      $display("row %0d done", r);
    end
    // receiver stalls: zero pairs fill the buffer, so a new pair is dropped
    @(posedge link.tx_clk);
    dac_ready_i <= 1'b0;
    repeat (20) @(posedge clock_i);
    dq.delete();
    send(24'hABC123);
    repeat (20) @(posedge link.tx_clk);
    dac_ready_i <= 1'b1;
    repeat (20) @(posedge clock_i);
    check(24'(dq.size()), 24'h0);
    $display("stall done");
    end_of_test();
  end
endmodule // baseband_iq_sample_interface_tb_top
`default_nettype wire

/* File: dv/iq_link_properties.sv */
// iq link checker: timing relations on the link wires and handshakes
// assumes link clocks come from clock_i and run a few cycles after reset
`default_nettype none
module iq_link_properties (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic tx_clk,
  input wire logic transmit_frame_sync,
  input wire logic rx_clk,
  input wire logic receive_frame_sync,
  input wire logic dac_clock_o,
  input wire logic adc_clock_o,
  input wire logic dac_valid_o,
  input wire logic dac_ready_i,
  input wire logic tx_ready_o,
  input wire logic rx_valid_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // link clocks and synced config settle after reset, so checks wait
  logic [4:0] age;
  wire        live = age[4];
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      age <= 5'h00;
    else if (!age[4])
      age <= age + 5'h01;
  end
  //////////////////////////////////////////////////////////////////////
  property p_tx_sync;
    @(posedge tx_clk) disable iff (!live) 1'b1 |-> $changed(transmit_frame_sync);
  endproperty
  a_tx_sync: assert property (p_tx_sync) else $error("tx sync held");
  property p_rx_sync;
    @(posedge rx_clk) disable iff (!live) 1'b1 |-> $changed(receive_frame_sync);
  endproperty
  a_rx_sync: assert property (p_rx_sync) else $error("rx sync held");
  property p_dac_clk;
    @(posedge tx_clk) disable iff (!live) $changed(transmit_frame_sync) |=> $changed(dac_clock_o);
  endproperty
  a_dac_clk: assert property (p_dac_clk) else $error("dac clock not from sync");
  property p_adc_clk;
    @(posedge rx_clk) disable iff (!live) 1'b1 |-> $changed(adc_clock_o);
  endproperty
  a_adc_clk: assert property (p_adc_clk) else $error("adc clock not halved");
  property p_rdy_gap;
    @(posedge clock_i) disable iff (!live) tx_ready_o |=> !tx_ready_o [*3];
  endproperty
  a_rdy_gap: assert property (p_rdy_gap) else $error("ready inside frame");
  property p_rdy_per;
    @(posedge clock_i) disable iff (!live) tx_ready_o |-> ##4 tx_ready_o;
  endproperty
  a_rdy_per: assert property (p_rdy_per) else $error("ready period wrong");
  property p_rx_pulse;
    @(posedge clock_i) disable iff (!live) rx_valid_o |=> !rx_valid_o;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("rx valid too long");
  property p_dac_hold;
    @(posedge tx_clk) disable iff (!live) dac_valid_o && !dac_ready_i |=> dac_valid_o;
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("dac pair lost");
  c_stall: cover property (@(posedge tx_clk) dac_valid_o && !dac_ready_i);
  c_dac: cover property (@(posedge tx_clk) dac_valid_o && dac_ready_i);
  c_rx: cover property (@(posedge clock_i) rx_valid_o);
endmodule // iq_link_properties
`default_nettype wire

/* File: hw/iq_baseband_end.sv */
// baseband end: sends i/q pairs, clocks the link, receives adc pairs
// assumes clock_i is the system clock; link clocks are clock_i divided by two
`include "iq_link_regs.svh"
`default_nettype none

module iq_baseband_end
  import iq_link_pkg::*;
(
  input  wire logic          clock_i,
  input  wire logic          rst_i,
  input  wire logic          tx_sync_pol_i,
  input  wire logic          tx_q_first_i,
  input  wire logic          rx_sync_pol_i,
  input  wire logic          rx_q_first_i,
  input  wire logic          tx_valid_i,
  input  wire iq_pair_t      tx_pair_i,
  output logic               tx_ready_o,
  output logic               rx_valid_o,
  output iq_pair_t           rx_pair_o,
  iq_link_if.baseband        link
);

  ////////////////////////////////////////////////////////////////////////////
  // link clock: both paths toggle every rising clock_i edge, word per link cycle
  logic     link_clk;
  logic     phase;
  iq_pair_t held;
  logic     tx_wd;
  logic     tx_fs;

  always_ff @(posedge clock_i)
    if (rst_i) link_clk <= 1'b0;
    else       link_clk <= ~link_clk;

  // phase 0: first word of frame; updates taken on falling link edge
  always_ff @(posedge clock_i)
    if (rst_i)          phase <= 1'b0;
    else if (link_clk)  phase <= ~phase;

  always_ff @(posedge clock_i)
    if (rst_i)
      held <= '0;
    else if (link_clk && phase && tx_valid_i)
      held <= tx_pair_i;
    else if (link_clk && phase)
      held <= '0;

  assign tx_ready_o = link_clk & phase;

  // sync level follows word type every word, continuous toggling
  always_ff @(posedge clock_i)
    if (rst_i)
    begin
      tx_wd <= 1'b0;
      tx_fs <= 1'b0;
    end
    else if (link_clk)
    begin
      tx_fs <= (phase ? tx_q_first_i : ~tx_q_first_i) ^ tx_sync_pol_i;
    end

  logic [11:0] tx_out;
  always_ff @(posedge clock_i)
    if (rst_i) tx_out <= '0;
    else if (link_clk)
      tx_out <= ((phase ? tx_q_first_i : ~tx_q_first_i) == 1'b1) ? held.i_word
                                                                  : held.q_word;

  assign link.tx_clk              = link_clk;
  assign link.rx_clk              = link_clk;
  assign link.tx_word             = tx_out;
  assign link.transmit_frame_sync = tx_fs;

  ////////////////////////////////////////////////////////////////////////////
  // receive: sample on rising link edge (clock_i edge where link_clk is 0)
  logic [11:0] first_word;
  logic        have_first;
  always_ff @(posedge clock_i)
    if (rst_i)
    begin
      have_first <= 1'b0;
      first_word <= '0;
      rx_valid_o <= 1'b0;
      rx_pair_o  <= '0;
    end
    else
    begin
      rx_valid_o <= 1'b0;
      if (!link_clk)
      begin
        if ((link.receive_frame_sync ^ rx_sync_pol_i) != rx_q_first_i)
        begin
          first_word <= link.rx_word;
          have_first <= 1'b1;
        end
        else if (have_first)
        begin
          have_first <= 1'b0;
          rx_valid_o <= 1'b1;
          rx_pair_o  <= rx_q_first_i ? {link.rx_word, first_word}
                                     : {first_word, link.rx_word};
        end
      end
    end

endmodule // iq_baseband_end

`default_nettype wire

/* File: hw/iq_converter_end.sv */
// converter end: tx/rx multiplexed iq path on the device side
// assumes baseband drives both link clocks; cfg written by its own port
`include "iq_link_regs.svh"
`default_nettype none

module iq_converter_end
  import iq_link_pkg::*;
#(
  parameter int DEPTH = `BUF_DEPTH
)
(
  input  wire logic                  reset_n_i,
  input  wire logic                  cfg_clock_i,
  input  wire logic                  cfg_write_i,
  input  wire logic [`CFG_WIDTH-1:0] cfg_wdata_i,
  output logic      [`CFG_WIDTH-1:0] cfg_rdata_o,
  output logic                       dac_clock_o,
  output logic                       dac_valid_o,
  output iq_pair_t                   dac_pair_o,
  input  wire logic                  dac_ready_i,
  input  wire logic                  adc_valid_i,
  input  wire iq_pair_t              adc_pair_i,
  output logic                       adc_ready_o,
  output logic                       adc_clock_o,
  iq_link_if.converter               link
);

  ////////////////////////////////////////////////////////////////////////////
  // configuration: async low reset restores defaults
  logic [`CFG_WIDTH-1:0] cfg;
  always_ff @(posedge cfg_clock_i or negedge reset_n_i)
    if (!reset_n_i)       cfg <= `CFG_RESET_VALUE;
    else if (cfg_write_i) cfg <= cfg_wdata_i;
  assign cfg_rdata_o = cfg;

  // cfg crosses into each link domain through two flops; bits are quasi-static
  logic [`CFG_WIDTH-1:0] tx_cfg_meta;
  logic [`CFG_WIDTH-1:0] tx_cfg;
  logic [`CFG_WIDTH-1:0] rx_cfg_meta;
  logic [`CFG_WIDTH-1:0] rx_cfg;

  always_ff @(posedge link.tx_clk or negedge reset_n_i)
    if (!reset_n_i)
    begin
      tx_cfg_meta <= `CFG_RESET_VALUE;
      tx_cfg      <= `CFG_RESET_VALUE;
    end
    else
    begin
      tx_cfg_meta <= cfg;
      tx_cfg      <= tx_cfg_meta;
    end

  always_ff @(posedge link.rx_clk or negedge reset_n_i)
    if (!reset_n_i)
    begin
      rx_cfg_meta <= `CFG_RESET_VALUE;
      rx_cfg      <= `CFG_RESET_VALUE;
    end
    else
    begin
      rx_cfg_meta <= cfg;
      rx_cfg      <= rx_cfg_meta;
    end

  wire tx_pol   = tx_cfg[`CFG_TX_SYNC_POL_BIT];
  wire tx_qf    = tx_cfg[`CFG_TX_Q_FIRST_BIT];
  wire dac_edge = tx_cfg[`CFG_TX_DAC_EDGE_BIT];
  wire rx_pol   = rx_cfg[`CFG_RX_SYNC_POL_BIT];
  wire rx_qf    = rx_cfg[`CFG_RX_Q_FIRST_BIT];
  wire adc_edge = rx_cfg[`CFG_RX_ADC_EDGE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // transmit path, own clock domain
  logic [11:0] tx_first;
  logic        tx_have;
  logic        fs_reg;
  iq_pair_t    buf_mem [DEPTH];
  logic [1:0]  wr_ptr;
  logic [1:0]  rd_ptr;
  wire  [1:0]  count = wr_ptr - rd_ptr;
  wire         full  = (count == 2'(DEPTH));
  logic        push;
  iq_pair_t    push_pair;

  // sync level xor polarity gives 1 for an i word
  wire is_i = link.transmit_frame_sync ^ tx_pol;
  wire is_first = is_i ^ tx_qf;

  // a pair needs both words; a lone first word is overwritten
  always_ff @(posedge link.tx_clk or negedge reset_n_i)
    if (!reset_n_i)
    begin
      tx_first  <= '0;
      tx_have   <= 1'b0;
      push      <= 1'b0;
      push_pair <= '0;
    end
    else
    begin
      push <= 1'b0;
      if (is_first)
      begin
        tx_first <= link.tx_word;
        tx_have  <= 1'b1;
      end
      else if (tx_have)
      begin
        tx_have   <= 1'b0;
        push      <= 1'b1;
        push_pair <= tx_qf ? {link.tx_word, tx_first}
                           : {tx_first, link.tx_word};
      end
    end

  // registered sync forms the dac clock; edge select inverts it
  always_ff @(posedge link.tx_clk or negedge reset_n_i)
    if (!reset_n_i) fs_reg <= 1'b0;
    else            fs_reg <= link.transmit_frame_sync;
  always_ff @(posedge link.tx_clk or negedge reset_n_i)
    if (!reset_n_i) dac_clock_o <= 1'b0;
    else            dac_clock_o <= fs_reg ^ dac_edge;

  // two-entry buffer; a stalled dac overwrites nothing, full drops new pair
  // entries hold no reset: their contents are only read behind valid
  for (genvar e = 0; e < DEPTH; e++)
  begin : g_entry
    always_ff @(posedge link.tx_clk)
      if (push && !full && (wr_ptr[0] == 1'(e)))
        buf_mem[e] <= push_pair;
  end
  // pointers carry one wrap bit so full and empty differ
  always_ff @(posedge link.tx_clk or negedge reset_n_i)
    if (!reset_n_i) wr_ptr <= '0;
    else if (push && !full) wr_ptr <= wr_ptr + 2'h1;
  always_ff @(posedge link.tx_clk or negedge reset_n_i)
    if (!reset_n_i) rd_ptr <= '0;
    else if (dac_valid_o && dac_ready_i) rd_ptr <= rd_ptr + 2'h1;
  always_comb
  begin
    dac_valid_o = (count != 2'h0);
    dac_pair_o  = buf_mem[rd_ptr[0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // receive path: adc clock is rx clock halved
  // second word comes from the held pair, never from a fresh conversion
  logic        rx_half;
  iq_pair_t    rx_hold;
  always_ff @(posedge link.rx_clk or negedge reset_n_i)
    if (!reset_n_i) rx_half <= 1'b0;
    else            rx_half <= ~rx_half;
  always_ff @(posedge link.rx_clk or negedge reset_n_i)
    if (!reset_n_i) adc_clock_o <= 1'b0;
    else            adc_clock_o <= rx_half ^ adc_edge;

  assign adc_ready_o = ~rx_half;

  always_ff @(posedge link.rx_clk or negedge reset_n_i)
    if (!reset_n_i)
    begin
      rx_hold                 <= '0;
      link.rx_word            <= '0;
      link.receive_frame_sync <= 1'b0;
    end
    else
    begin
      if (!rx_half)
      begin
        // one conversion supplies both words of the frame
        rx_hold <= adc_valid_i ? adc_pair_i : '0;
        link.rx_word <= rx_qf ? (adc_valid_i ? adc_pair_i.q_word : 12'h000)
                              : (adc_valid_i ? adc_pair_i.i_word : 12'h000);
        link.receive_frame_sync <= rx_qf ^ ~rx_pol ^ 1'b1 ^ 1'b1;
      end
      else
      begin
        link.rx_word <= rx_qf ? rx_hold.i_word : rx_hold.q_word;
        link.receive_frame_sync <= ~(rx_qf ^ ~rx_pol);
      end
    end

endmodule // iq_converter_end

`default_nettype wire

/* File: hw/iq_link_if.sv */
// iq link wires between baseband end and converter end
// assumes one clock on each path driven by the baseband
`default_nettype none

interface iq_link_if;
  logic        tx_clk;
  logic [11:0] tx_word;
  logic        transmit_frame_sync;
  logic        rx_clk;
  logic [11:0] rx_word;
  logic        receive_frame_sync;

  modport converter
  (
    input  tx_clk,
    input  tx_word,
    input  transmit_frame_sync,
    input  rx_clk,
    output rx_word,
    output receive_frame_sync
  );

  modport baseband
  (
    output tx_clk,
    output tx_word,
    output transmit_frame_sync,
    output rx_clk,
    input  rx_word,
    input  receive_frame_sync
  );
endinterface

`default_nettype wire

/* File: hw/iq_link_pkg.sv */
// iq link types shared by both ends
// assumes the constants header sits beside it
`default_nettype none

package iq_link_pkg;
  typedef logic [11:0] sample_t;
  typedef struct packed
  {
    sample_t i_word;
    sample_t q_word;
  } iq_pair_t;
endpackage

`default_nettype wire

/* File: hw/iq_link_regs.svh */
// iq link constants: configuration bit positions, reset values and widths
// assumes inclusion by bare name from the iq link design files
`ifndef IQ_LINK_REGS_SVH
`define IQ_LINK_REGS_SVH

`define IQ_WORD_WIDTH       12
`define CFG_WIDTH           8
// configuration bit positions
`define CFG_TX_SYNC_POL_BIT 0
`define CFG_TX_Q_FIRST_BIT  1
`define CFG_TX_DAC_EDGE_BIT 2
`define CFG_RX_SYNC_POL_BIT 3
`define CFG_RX_Q_FIRST_BIT  4
`define CFG_RX_ADC_EDGE_BIT 5
// all fields reset to zero: sync high marks i, i first, rising sample edge
`define CFG_RESET_VALUE     8'h00
`define BUF_DEPTH           2

`endif
